//--- async_serial_pkg.sv
/*
  Constants, field positions and carrier types shared by the asynchronous
  serial channel. Assumes a single 10 MHz core clock and an 8-bit register port.
*/
package async_serial_pkg;

  localparam int CLK_HZ = 10_000_000;

  // Register offsets on the plain register port
  localparam logic [3:0] MODE_FORMAT_ADDR = 4'h0;
  localparam logic [3:0] RECEIVE_CONTROL_ADDR = 4'h1;
  localparam logic [3:0] TRANSMIT_CONTROL_ADDR = 4'h2;
  localparam logic [3:0] DATA_ADDR = 4'h3;
  localparam logic [3:0] LINE_STATUS_ADDR = 4'h4;
  localparam logic [3:0] SPECIAL_STATUS_ADDR = 4'h5;
  localparam logic [3:0] DIVISOR_LOW_ADDR = 4'h6;
  localparam logic [3:0] DIVISOR_HIGH_ADDR = 4'h7;

  // Mode/format register fields
  localparam int MF_PARITY_EN = 0;
  localparam int MF_PARITY_EVEN = 1;
  localparam int MF_STOP_LO = 2;
  localparam int MF_STOP_HI = 3;
  localparam int MF_FACTOR_LO = 6;
  localparam int MF_FACTOR_HI = 7;

  // Receive control register fields
  localparam int RC_ENABLE = 0;
  localparam int RC_SPECIAL_EN = 1;
  localparam int RC_LEN_LO = 6;
  localparam int RC_LEN_HI = 7;

  // Transmit control register fields
  localparam int TC_ENABLE = 3;
  localparam int TC_BREAK = 4;
  localparam int TC_LEN_LO = 5;
  localparam int TC_LEN_HI = 6;

  // Status bit positions
  localparam int LS_RX_AVAIL = 0;
  localparam int LS_TX_EMPTY = 2;
  localparam int LS_BREAK = 7;
  localparam int SS_ALL_SENT = 0;
  localparam int SS_PARITY_ERR = 4;
  localparam int SS_OVERRUN = 5;
  localparam int SS_FRAMING_ERR = 6;

  // Stop field codes; 00 stands for the synchronous modes
  localparam logic [1:0] STOP_SYNC = 2'h0;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] STOP_ONE_HALF = 2'h2;

  // Clock factor codes
  localparam logic [1:0] FACTOR_X1 = 2'h0;
  localparam logic [1:0] FACTOR_X16 = 2'h1;
  localparam logic [1:0] FACTOR_X32 = 2'h2;

  localparam int RX_QUEUE_DEPTH = 3;
  localparam int ASM_WIDTH = 12;
  localparam int SHORT_TOP = 8;

  typedef struct packed {
    logic [7:0] data;
    logic parityErr;
    logic framingErr;
  } rx_entry_t;

endpackage : async_serial_pkg

//--- async_serial_channel.sv
/*
  Asynchronous receiver and transmitter of one serial channel with its
  register file. Assumes rxd comes from an unsynchronised pin and the register
  port master is on ref_clk. The bit-rate clock is a tick from a divider.
*/
// Operation
// - Falling edge, half bit, recheck low
// - Strip start/stop; keep parity if under eight
// - Low stop sample sets framing error
// - High stop sample returns to idle
// - Long characters pass three-stage delay first
// - Framing flag travels; raises special condition
// - Framing error adds half bit
// - Null plus framing error sets break
// - Break end leaves one null character
// - Clock factor 1/16/32/64 shared both ways
// - Times-one starts one clock after edge
// - Synchronous modes force times-one clock
// - Async transmitter frames, no sync, no CRC
// - Idle high; load sets buffer empty
// - Start, parity, stops; then reload
// - All-sent set at last stop
// - Transmit stop count selectable; receive one
// - Parity enable and even/odd select
// - Transmit length five to eight
// - Least significant bit sent first
`timescale 1ns/1ps
module async_serial_channel
  import async_serial_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rxd,
  output logic txd,
  output logic specialCondition
);

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_EXTRA} rx_state_t;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;

  function automatic logic [3:0] charBits(input logic [1:0] code);
    charBits = 4'h5 + {2'b00, code};
  endfunction : charBits

  function automatic logic [6:0] bitTicks(input logic [1:0] factor, input logic [1:0] stop);
    if (stop == STOP_SYNC) begin
      bitTicks = 7'h01;
    end else begin
      case (factor)
        FACTOR_X1: bitTicks = 7'h01;
        FACTOR_X16: bitTicks = 7'h10;
        FACTOR_X32: bitTicks = 7'h20;
        default: bitTicks = 7'h40;
      endcase
    end
  endfunction : bitTicks

  function automatic logic [8:0] lowMask(input logic [3:0] n);
    lowMask = 9'h1ff >> (4'h9 - n);
  endfunction : lowMask

  logic [7:0] modeFormat;
  logic [7:0] receiveControl;
  logic [7:0] transmitControl;
  logic [15:0] divisor;
  logic [15:0] divCnt;
  logic tick;

  logic parityEn;
  logic parityEven;
  logic [1:0] stopSel;
  logic [6:0] bitT;
  logic [6:0] halfT;
  logic [6:0] stopT;

  assign parityEn = modeFormat[MF_PARITY_EN];
  assign parityEven = modeFormat[MF_PARITY_EVEN];
  assign stopSel = modeFormat[MF_STOP_HI:MF_STOP_LO];
  assign bitT = bitTicks(modeFormat[MF_FACTOR_HI:MF_FACTOR_LO], stopSel);
  // Times-one has no half bit, so one clock stands in for it
  assign halfT = (bitT == 7'h01) ? 7'h01 : (bitT >> 1);

  // Stop time in ticks; 1.5 stops at times-one is treated as two
  always_comb begin
    case (stopSel)
      STOP_SYNC: stopT = bitT;
      STOP_ONE: stopT = bitT;
      STOP_ONE_HALF: stopT = (bitT == 7'h01) ? 7'h02 : (bitT + halfT);
      default: stopT = bitT << 1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      modeFormat <= 8'h04;
      receiveControl <= 8'h00;
      transmitControl <= 8'h00;
      divisor <= 16'h0000;
    end else if (wr) begin
      case (addr)
        MODE_FORMAT_ADDR: modeFormat <= wdata;
        RECEIVE_CONTROL_ADDR: receiveControl <= wdata;
        TRANSMIT_CONTROL_ADDR: transmitControl <= wdata;
        DIVISOR_LOW_ADDR: divisor[7:0] <= wdata;
        DIVISOR_HIGH_ADDR: divisor[15:8] <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      divCnt <= 16'h0000;
    end else if (divCnt == 16'h0000) begin
      divCnt <= divisor;
    end else begin
      divCnt <= divCnt - 16'h0001;
    end
  end
  assign tick = (divCnt == 16'h0000);

  // Receiver
  logic rxMeta;
  logic rxLine;
  logic rxPrev;
  rx_state_t rxState;
  logic [6:0] rxCnt;
  logic [3:0] rxLeft;
  logic [ASM_WIDTH-1:0] asmReg;
  logic breakFlag;
  logic stopPush;
  rx_entry_t stopEntry;
  logic rxEnable;
  logic [3:0] rxLen;
  logic [3:0] rxTotal;
  logic rxLong;
  logic [8:0] rxJust;
  logic [8:0] rxKept;
  logic rxZero;
  logic rxParErr;
  logic breakEnd;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxMeta <= 1'b1;
      rxLine <= 1'b1;
      rxPrev <= 1'b1;
    end else begin
      rxMeta <= rxd;
      rxLine <= rxMeta;
      rxPrev <= rxLine;
    end
  end

  assign rxEnable = receiveControl[RC_ENABLE];
  assign rxLen = charBits(receiveControl[RC_LEN_HI:RC_LEN_LO]);
  assign rxTotal = rxLen + {3'b000, parityEn};
  assign rxLong = (rxLen > 4'h6);
  // Right-justify the assembled bits from wherever the path left them
  assign rxJust = rxLong ? 9'(asmReg >> (4'hc - rxTotal))
                         : 9'(asmReg[SHORT_TOP:0] >> (4'h9 - rxTotal));
  assign rxKept = rxJust & lowMask((parityEn && rxLen < 4'h8) ? rxTotal : rxLen);
  assign rxZero = ((rxJust & lowMask(rxLen)) == 9'h000);
  assign rxParErr = parityEn && (parityEven ? ^(rxJust & lowMask(rxTotal))
                                            : ~^(rxJust & lowMask(rxTotal)));

  assign stopPush = (rxState == RX_STOP) && tick && (rxCnt == 7'h01);
  assign stopEntry = '{data: rxKept[7:0], parityErr: rxParErr, framingErr: ~rxLine};
  assign breakEnd = breakFlag && rxLine;

  always_ff @(posedge ref_clk) begin
    if (rst || !rxEnable) begin
      rxState <= RX_IDLE;
      rxCnt <= 7'h00;
      rxLeft <= 4'h0;
      asmReg <= '0;
    end else begin
      case (rxState)
        RX_IDLE: begin
          if (rxPrev && !rxLine) begin
            if (bitT == 7'h01) begin
              // Times-one: the edge cycle is the start bit, so the next clock is data
              rxState <= RX_DATA;
              rxCnt <= bitT;
              rxLeft <= rxTotal;
              asmReg <= '0;
            end else begin
              rxState <= RX_START;
              rxCnt <= halfT;
            end
          end
        end
        RX_START: begin
          if (tick) begin
            if (rxCnt != 7'h01) begin
              rxCnt <= rxCnt - 7'h01;
            end else if (!rxLine) begin
              rxState <= RX_DATA;
              rxCnt <= bitT;
              rxLeft <= rxTotal;
              asmReg <= '0;
            end else begin
              rxState <= RX_IDLE;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            if (rxCnt != 7'h01) begin
              rxCnt <= rxCnt - 7'h01;
            end else begin
              rxCnt <= bitT;
              rxLeft <= rxLeft - 4'h1;
              if (rxLong) begin
                asmReg <= {rxLine, asmReg[ASM_WIDTH-1:1]};
              end else begin
                asmReg <= {3'b000, rxLine, asmReg[SHORT_TOP:1]};
              end
              if (rxLeft == 4'h1) begin
                rxState <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            if (rxCnt != 7'h01) begin
              rxCnt <= rxCnt - 7'h01;
            end else if (!rxLine) begin
              rxState <= RX_EXTRA;
              rxCnt <= halfT;
            end else begin
              rxState <= RX_IDLE;
            end
          end
        end
        RX_EXTRA: begin
          if (tick) begin
            if (rxCnt != 7'h01) begin
              rxCnt <= rxCnt - 7'h01;
            end else begin
              rxState <= RX_IDLE;
            end
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      breakFlag <= 1'b0;
    end else if (stopPush && !rxLine && rxZero) begin
      breakFlag <= 1'b1;
    end else if (breakEnd) begin
      breakFlag <= 1'b0;
    end
  end

  // Receive data and error queue
  rx_entry_t rxQueue [RX_QUEUE_DEPTH];
  logic [1:0] qWr;
  logic [1:0] qRd;
  logic [1:0] qCount;
  logic qPush;
  logic qPop;
  logic qFull;
  rx_entry_t qIn;
  rx_entry_t qHead;
  logic overrun;

  // A null pushed at break end; the stop push wins if both fall together
  assign qPush = stopPush || breakEnd;
  assign qIn = stopPush ? stopEntry
                        : '{data: 8'h00, parityErr: parityEn && !parityEven, framingErr: 1'b0};
  assign qPop = rd && (addr == DATA_ADDR) && (qCount != 2'h0);
  assign qFull = (qCount == 2'(RX_QUEUE_DEPTH));
  assign qHead = rxQueue[qRd];

  always_ff @(posedge ref_clk) begin
    if (qPush && (!qFull || qPop)) begin
      rxQueue[qWr] <= qIn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      qWr <= 2'h0;
      qRd <= 2'h0;
      qCount <= 2'h0;
    end else begin
      if (qPush && (!qFull || qPop)) begin
        qWr <= (qWr == 2'(RX_QUEUE_DEPTH - 1)) ? 2'h0 : qWr + 2'h1;
      end
      if (qPop) begin
        qRd <= (qRd == 2'(RX_QUEUE_DEPTH - 1)) ? 2'h0 : qRd + 2'h1;
      end
      if ((qPush && (!qFull || qPop)) && !qPop) begin
        qCount <= qCount + 2'h1;
      end else if (qPop && !qPush) begin
        qCount <= qCount - 2'h1;
      end
    end
  end

  // Overrun clears on a special status read; a new overrun in that cycle wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      overrun <= 1'b0;
    end else if (qPush && qFull && !qPop) begin
      overrun <= 1'b1;
    end else if (rd && addr == SPECIAL_STATUS_ADDR) begin
      overrun <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      specialCondition <= 1'b0;
    end else begin
      specialCondition <= receiveControl[RC_SPECIAL_EN] && (qCount != 2'h0)
                          && (qHead.framingErr || qHead.parityErr);
    end
  end

  // Transmitter
  tx_state_t txState;
  logic [7:0] txBuf;
  logic txBufEmpty;
  logic [7:0] txShift;
  logic [3:0] txLeft;
  logic [6:0] txCnt;
  logic txOut;
  logic txParity;
  logic allSent;
  logic txEnable;
  logic [3:0] txLen;
  logic txLoad;
  logic txBitEnd;
  logic bufWrite;

  assign txEnable = transmitControl[TC_ENABLE];
  assign txLen = charBits(transmitControl[TC_LEN_HI:TC_LEN_LO]);
  assign txBitEnd = tick && (txCnt == 7'h01);
  assign txLoad = txEnable && !txBufEmpty
                  && ((txState == TX_IDLE) || (txState == TX_STOP && txBitEnd));
  assign bufWrite = wr && (addr == DATA_ADDR);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txState <= TX_IDLE;
      txBuf <= 8'h00;
      txBufEmpty <= 1'b1;
      txShift <= 8'h00;
      txLeft <= 4'h0;
      txCnt <= 7'h00;
      txOut <= 1'b1;
      txParity <= 1'b0;
    end else begin
      if (txLoad) begin
        txShift <= txBuf;
        txBufEmpty <= 1'b1;
        txParity <= parityEven ? ^(9'(txBuf) & lowMask(txLen))
                               : ~^(9'(txBuf) & lowMask(txLen));
        txState <= TX_START;
        txOut <= 1'b0;
        txCnt <= bitT;
      end else if (tick && txState != TX_IDLE) begin
        if (txCnt != 7'h01) begin
          txCnt <= txCnt - 7'h01;
        end else begin
          txCnt <= bitT;
          case (txState)
            TX_START: begin
              txState <= TX_DATA;
              txOut <= txShift[0];
              txShift <= txShift >> 1;
              txLeft <= txLen - 4'h1;
            end
            TX_DATA: begin
              if (txLeft != 4'h0) begin
                txOut <= txShift[0];
                txShift <= txShift >> 1;
                txLeft <= txLeft - 4'h1;
              end else if (parityEn) begin
                txState <= TX_PARITY;
                txOut <= txParity;
              end else begin
                txState <= TX_STOP;
                txOut <= 1'b1;
                txCnt <= stopT;
              end
            end
            TX_PARITY: begin
              txState <= TX_STOP;
              txOut <= 1'b1;
              txCnt <= stopT;
            end
            TX_STOP: txState <= TX_IDLE;
            default: txState <= TX_IDLE;
          endcase
        end
      end
      if (bufWrite) begin
        txBuf <= wdata;
        txBufEmpty <= 1'b0;
      end
    end
  end

  // Set at the end of the last stop with nothing queued; set beats a write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      allSent <= 1'b1;
    end else if (txState == TX_STOP && txBitEnd && !txLoad) begin
      allSent <= 1'b1;
    end else if (bufWrite) begin
      allSent <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txd <= 1'b1;
    end else begin
      txd <= transmitControl[TC_BREAK] ? 1'b0 : txOut;
    end
  end

  // Register read port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= 8'h00;
      case (addr)
        MODE_FORMAT_ADDR: rdata <= modeFormat;
        RECEIVE_CONTROL_ADDR: rdata <= receiveControl;
        TRANSMIT_CONTROL_ADDR: rdata <= transmitControl;
        DATA_ADDR: rdata <= (qCount != 2'h0) ? qHead.data : 8'h00;
        LINE_STATUS_ADDR: begin
          rdata[LS_RX_AVAIL] <= (qCount != 2'h0);
          rdata[LS_TX_EMPTY] <= txBufEmpty;
          rdata[LS_BREAK] <= breakFlag;
        end
        SPECIAL_STATUS_ADDR: begin
          rdata[SS_ALL_SENT] <= allSent;
          rdata[SS_PARITY_ERR] <= (qCount != 2'h0) && qHead.parityErr;
          rdata[SS_OVERRUN] <= overrun;
          rdata[SS_FRAMING_ERR] <= (qCount != 2'h0) && qHead.framingErr;
        end
        DIVISOR_LOW_ADDR: rdata <= divisor[7:0];
        DIVISOR_HIGH_ADDR: rdata <= divisor[15:8];
        default: rdata <= 8'h00;
      endcase
    end
  end

endmodule : async_serial_channel

//--- async_serial_channel_monitor.sv
/* Port checker for the asynchronous serial channel.
   Assumes it is bound to the channel and sees only its ports. */
`timescale 1ns/1ps
module async_serial_channel_monitor
  import async_serial_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rxd,
  input wire logic txd,
  input wire logic specialCondition
);
  logic [7:0] mode;
  logic [7:0] txCtl;
  logic [15:0] divisor;
  logic spEn;
  logic rxEver;
  logic dataWritten;
  int lowRun;
  int bitClks;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Shadow of the writable settings, updated on the same edge as the design
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode <= 8'h04;
      txCtl <= 8'h00;
      divisor <= 16'h0000;
      spEn <= 1'b0;
      rxEver <= 1'b0;
      dataWritten <= 1'b0;
    end else if (wr) begin
      case (addr)
        MODE_FORMAT_ADDR: mode <= wdata;
        RECEIVE_CONTROL_ADDR: begin
          spEn <= wdata[RC_SPECIAL_EN];
          rxEver <= rxEver | wdata[RC_ENABLE];
        end
        TRANSMIT_CONTROL_ADDR: txCtl <= wdata;
        DATA_ADDR: dataWritten <= 1'b1;
        DIVISOR_LOW_ADDR: divisor[7:0] <= wdata;
        DIVISOR_HIGH_ADDR: divisor[15:8] <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || txd) begin
      lowRun <= 0;
    end else begin
      lowRun <= lowRun + 1;
    end
  end

  // Synchronous modes fall back to one tick per bit
  assign bitClks = ((mode[3:2] == STOP_SYNC || mode[7:6] == FACTOR_X1) ? 1 :
    (8 << mode[7:6])) * (int'(divisor) + 1);

  property p_reset_idle;
    disable iff (1'b0) rst |=> txd && !specialCondition && rdata == 8'h00;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");

  property p_idle_high;
    !dataWritten && !txCtl[TC_BREAK] |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("txd left mark with nothing sent");

  property p_first_start;
    wr && addr == DATA_ADDR && !dataWritten && txCtl[TC_ENABLE] && !txCtl[TC_BREAK]
      |-> ##[1:3] !txd;
  endproperty
  a_first_start: assert property (p_first_start) else $error("no start bit after load");

  property p_low_multiple;
    txd && !$past(txd) && !txCtl[TC_BREAK] |-> lowRun % bitClks == 0;
  endproperty
  a_low_multiple: assert property (p_low_multiple) else $error("low run not whole bits");

  property p_low_max;
    !txCtl[TC_BREAK] |-> lowRun <= 10 * bitClks;
  endproperty
  a_low_max: assert property (p_low_max) else $error("txd low longer than a frame");

  property p_spc_disabled;
    !spEn && !$past(spEn) |-> !specialCondition;
  endproperty
  a_spc_disabled: assert property (p_spc_disabled) else $error("special while disabled");

  property p_spc_needs_rx;
    !rxEver |-> !specialCondition;
  endproperty
  a_spc_needs_rx: assert property (p_spc_needs_rx) else $error("special with no receive");

  property p_rdata_holds;
    !$past(rd) && !$past(rst) |-> $stable(rdata);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without read");

  c_special: cover property ($rose(specialCondition));
  c_start: cover property ($fell(txd));
  c_unmapped: cover property (rd && addr[3]);
endmodule : async_serial_channel_monitor

bind async_serial_channel async_serial_channel_monitor u_async_serial_channel_monitor (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .rxd(rxd), .txd(txd), .specialCondition(specialCondition));

//--- remote_terminal.sv
/* Remote serial terminal: sends frames on rxd and captures frames from txd.
   Assumes it shares ref_clk with the channel and is driven by tasks from tb. */
`timescale 1ns/1ps
module remote_terminal (
  input wire logic ref_clk,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;

  // Line changes just after an edge, so x1 data stays in step with the clock
  task automatic send(input logic [7:0] d, input int len, input logic pe, input logic pv,
      input logic stopLvl, input int tail, input int b);
    logic [11:0] f;
    int n;
    f = 12'h000;
    for (int i = 0; i < len; i++) f[i + 1] = d[i];
    n = len + 1;
    if (pe) begin
      f[n] = pv;
      n++;
    end
    f[n] = stopLvl;
    for (int i = 0; i <= n + tail; i++) begin
      @(posedge ref_clk);
      rxd <= (i > n) ? stopLvl : f[i];
      repeat (b - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    rxd <= 1'b1;
  endtask : send

  // Period runs from this start edge to the next one, or 40 bits if none follows
  task automatic catch_frame(input int n, input int b, output logic [11:0] bits,
      output int period);
    int k;
    bits = 12'hfff;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (txd !== 1'b0 && k < 4000);
    period = -1;
    if (k < 4000) begin
      repeat (b / 2) @(posedge ref_clk);
      bits[0] = txd;
      for (int i = 1; i < n; i++) begin
        repeat (b) @(posedge ref_clk);
        bits[i] = txd;
      end
      k = b / 2 + (n - 1) * b;
      while (txd !== 1'b0 && k < 40 * b) begin
        @(posedge ref_clk);
        k++;
      end
      period = k;
    end
  endtask : catch_frame
endmodule : remote_terminal

//--- tb.sv
/* Self-checking bench for the asynchronous serial channel.
   Assumes a 10 MHz ref_clk and the remote terminal on the serial pins. */
`timescale 1ns/1ps
module tb;
  import async_serial_pkg::*;
  typedef struct {
    logic [7:0] mode;
    logic [1:0] len;
    logic [7:0] data;
  } row_t;
  logic ref_clk, rst, wr, rd, rxd, txd, specialCondition;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, got, d, exp;
  logic [11:0] bits;
  logic pe, pv;
  int num_errors, n_tests, period, b, len;
  // x1 row keeps one stop bit, since 1.5 is not allowed there; last row uses stop code 00
  row_t rows [7] = '{'{8'h44, 2'h3, 8'ha5}, '{8'h47, 2'h2, 8'h35}, '{8'h45, 2'h0, 8'h13},
    '{8'h8f, 2'h1, 8'h2c}, '{8'hc5, 2'h3, 8'h81}, '{8'h04, 2'h3, 8'h5a},
    '{8'hc0, 2'h3, 8'h3c}};

  async_serial_channel u_async_serial_channel (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd),
    .specialCondition(specialCondition));
  remote_terminal u_remote_terminal (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [11:0] e, input logic [11:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask : check

  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
    v = rdata;
  endtask : rreg

  task automatic grab(input int n, input int bc);
    u_remote_terminal.catch_frame(n, bc, bits, period);
    if (period < 0) begin
      num_errors++;
      stop_test();
    end
  endtask : grab

  function automatic logic [11:0] frame(input logic [7:0] dv, input int n, input logic p,
      input logic v);
    logic [11:0] f;
    f = 12'hffe;
    for (int j = 0; j < n; j++) f[j + 1] = dv[j];
    if (p) f[n + 1] = v;
    return f;
  endfunction : frame

  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      b = (rows[i].mode[7:6] == FACTOR_X1 || rows[i].mode[3:2] == STOP_SYNC) ? 1
        : 8 << rows[i].mode[7:6];
      len = 5 + rows[i].len;
      pe = rows[i].mode[MF_PARITY_EN];
      d = rows[i].data & (8'hff >> (8 - len));
      pv = ^d ^ ~rows[i].mode[MF_PARITY_EVEN];
      wreg(MODE_FORMAT_ADDR, rows[i].mode);
      wreg(TRANSMIT_CONTROL_ADDR, {1'b0, rows[i].len, 5'h08});
      wreg(RECEIVE_CONTROL_ADDR, {rows[i].len, 6'h01});
      u_remote_terminal.send(rows[i].data, len, pe, pv, 1'b1, 0, b);
      repeat (4 * b + 4) @(posedge ref_clk);
      rreg(SPECIAL_STATUS_ADDR, got);
      check("rx errors", 12'h0, {4'h0, got & 8'h50});
      rreg(DATA_ADDR, got);
      exp = d;
      if (pe && len < 8) exp[len] = pv;
      check("rx data", {4'h0, exp}, {4'h0, got});
      fork
        wreg(DATA_ADDR, rows[i].data);
        grab(len + pe + 2, b);
      join
      check("tx frame", frame(d, len, pe, pv), bits);
      rreg(SPECIAL_STATUS_ADDR, got);
      check("all sent", 12'h1, {4'h0, got & 8'h01});
      rreg(LINE_STATUS_ADDR, got);
      check("tx empty", 12'h4, {4'h0, got & 8'h04});
    end
    for (int s = 0; s < 2; s++) begin
      wreg(MODE_FORMAT_ADDR, (s == 1) ? 8'h4c : 8'h48);
      wreg(TRANSMIT_CONTROL_ADDR, 8'h08);
      fork
        begin
          wreg(DATA_ADDR, 8'h1f);
          wreg(DATA_ADDR, 8'h02);
        end
        grab(7, 16);
      join
      check("stop period", (s == 1) ? 12'd128 : 12'd120, period[11:0]);
      grab(7, 16);
      check("reload frame", frame(8'h02, 5, 1'b0, 1'b0), bits);
    end
    wreg(MODE_FORMAT_ADDR, 8'h45);
    wreg(RECEIVE_CONTROL_ADDR, 8'hc3);
    fork
      u_remote_terminal.send(8'h00, 8, 1'b1, 1'b0, 1'b0, 15, 16);
      begin
        repeat (300) @(posedge ref_clk);
        check("special", 12'h1, {11'h0, specialCondition});
        rreg(LINE_STATUS_ADDR, got);
        check("break set", 12'h80, {4'h0, got & 8'h80});
      end
    join
    repeat (100) @(posedge ref_clk);
    rreg(SPECIAL_STATUS_ADDR, got);
    check("framing", 12'h40, {4'h0, got & 8'h40});
    rreg(DATA_ADDR, got);
    check("null data", 12'h0, {4'h0, got});
    rreg(SPECIAL_STATUS_ADDR, got);
    check("break end", 12'h10, {4'h0, got & 8'h50});
    rreg(DATA_ADDR, got);
    rreg(LINE_STATUS_ADDR, got);
    check("queue empty", 12'h0, {4'h0, got & 8'h81});
    wreg(MODE_FORMAT_ADDR, 8'h44);
    u_remote_terminal.send(8'h00, 0, 1'b0, 1'b0, 1'b1, 0, 4);
    repeat (60) @(posedge ref_clk);
    rreg(LINE_STATUS_ADDR, got);
    check("glitch", 12'h0, {4'h0, got & 8'h01});
    // Sixteen clocks of break keep the low run a whole bit at x16
    wreg(TRANSMIT_CONTROL_ADDR, 8'h18);
    repeat (14) @(posedge ref_clk);
    check("break out", 12'h0, {11'h0, txd});
    wreg(TRANSMIT_CONTROL_ADDR, 8'h08);
    wreg(4'h9, 8'h5a);
    rreg(4'h9, got);
    check("unmapped", 12'h0, {4'h0, got});
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("reset", 12'h200, {2'h0, txd, specialCondition, rdata});
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    stop_test();
  end
endmodule : tb
